// [design/fspu_pkg.sv]
// constants and types of the flash self-programming unit
package fspu_pkg;
  // ==========================================================
  // register map and fields
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ZPTR   = 8'h04;
  localparam logic [7:0] OFF_DATA   = 8'h08;
  localparam logic [7:0] OFF_INSN   = 8'h0c;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int         BIT_EN     = 0;
  localparam int         BIT_IE     = 7;
  localparam int         INSN_SPM   = 0;
  localparam int         INSN_LPM   = 1;
  localparam int         Z_W        = 16;
  localparam int         WORD_W     = 16;
  // ==========================================================
  // command patterns, low six bits of the control register
  localparam logic [5:0] CMD_LOAD   = 6'h01;
  localparam logic [5:0] CMD_ERASE  = 6'h03;
  localparam logic [5:0] CMD_WRITE  = 6'h05;
  localparam logic [5:0] CMD_LOCK   = 6'h09;
  localparam logic [5:0] CMD_REEN   = 6'h11;
  // ==========================================================
  // timing windows in cycles, lock and fuse addresses, values
  localparam logic [2:0]  SPM_WIN     = 3'h4;
  localparam logic [2:0]  LPM_WIN     = 3'h3;
  localparam logic [15:0] Z_FUSE_LO   = 16'h0000;
  localparam logic [15:0] Z_LOCK      = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] Z_FUSE_HI   = 16'h0003;
  localparam logic [1:0]  LOCK_RD_PAD = 2'h3;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} fspu_state_t;
  typedef enum logic [1:0] {OP_ERASE, OP_WRITE, OP_LOCK} fspu_op_t;
endpackage : fspu_pkg

// [design/fspu_buf_if.sv]
// carrier between sequencer and temporary page buffer
`timescale 1ns/10ps
interface fspu_buf_if #(parameter int PW = 32) ();
  logic                  wr;
  logic [$clog2(PW)-1:0] wrIdx;
  logic [15:0]           wrData;
  logic                  clr;
  logic [$clog2(PW)-1:0] rdIdx;
  logic [15:0]           rdData;
  logic                  loaded;
  modport ctl   (output wr, wrIdx, wrData, clr, rdIdx, input rdData, loaded);
  modport store (input wr, wrIdx, wrData, clr, rdIdx, output rdData, loaded);
endinterface : fspu_buf_if

// [design/fspu_page_buf.sv]
// temporary page buffer with per-slot valid bits
`timescale 1ns/10ps
module fspu_page_buf #(
  parameter int PW = 32               // words per page
) (
  input  wire logic core_clk,         // cpu clock
  input  wire logic rst_n,            // async reset, active low
  fspu_buf_if.store bus               // load, clear and read port
);
  import fspu_pkg::*;
  if (PW < 2 || PW > 128) $error("fspu_page_buf: PW out of range");
  typedef struct packed {
    logic [PW-1:0][WORD_W-1:0] mem;
    logic [PW-1:0]             vld;
  } fspu_buf_st_t;
  fspu_buf_st_t s;
  fspu_buf_st_t next_s;

  // ==========================================================
  // load and clear
  always_comb
  begin
    next_s = s;
    // clear beats a load in the same cycle
    if (bus.clr)
      next_s.vld = '0;
    else if (bus.wr)
    begin
      next_s.mem[bus.wrIdx] = bus.wrData;
      next_s.vld[bus.wrIdx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // unloaded slots read as erased flash
  assign bus.rdData = s.vld[bus.rdIdx] ? s.mem[bus.rdIdx] : ERASED_WORD;
  assign bus.loaded = |s.vld;

  a_buf_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.clr |=> !bus.loaded) else $error("buffer not empty after clear");
endmodule : fspu_page_buf

// [design/fspu_window.sv]
// store and load instruction timing window after a command write
`timescale 1ns/10ps
module fspu_window (
  input  wire logic core_clk,   // cpu clock
  input  wire logic rst_n,      // async reset, active low
  input  wire logic arm,        // command written, window opens
  input  wire logic cancel,     // instruction consumed the window
  output logic      spmOk,      // store instruction allowed now
  output logic      lpmOk,      // load instruction allowed now
  output logic      expire      // window lapsed unused, one cycle
);
  import fspu_pkg::*;
  typedef struct packed {
    logic [2:0] cnt;
  } fspu_win_st_t;
  fspu_win_st_t s;
  fspu_win_st_t next_s;

  // ==========================================================
  // countdown
  always_comb
  begin
    next_s = s;
    if (arm)
      next_s.cnt = SPM_WIN;
    else if (cancel)
      next_s.cnt = 3'h0;
    else if (s.cnt != 3'h0)
      next_s.cnt = s.cnt - 3'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // four cycles for store, three for load
  assign spmOk  = s.cnt != 3'h0;
  assign lpmOk  = s.cnt > (SPM_WIN - LPM_WIN);
  assign expire = s.cnt == 3'h1 && !arm && !cancel;

  sequence quietRun4;
    (!arm && !cancel) [*4];
  endsequence
  sequence quietRun3;
    (!arm && !cancel) [*3];
  endsequence
  a_spm_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    arm ##1 quietRun4 |=> !spmOk) else $error("store window too long");
  a_spm_open: assert property (@(posedge core_clk) disable iff (!rst_n)
    arm |=> spmOk) else $error("store window not open");
  a_lpm_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    arm ##1 quietRun3 |=> !lpmOk) else $error("load window too long");
endmodule : fspu_window

// [design/fspu_top.sv]
// flash self-programming unit: apb registers, sequencer, lock and fuse read
// ==========================================================
// Function
// - erase runs on pattern, store within four
// - erase uses only the page index
// - load puts data word at word slot
// - buffer cleared after write, re-enable, reset
// - eeprom write discards loaded buffer words
// - write runs on pattern, store within four
// - halting region target stalls the cpu
// - target address latched at operation start
// - interrupt is a level while enable clear
// - busy flag holds until re-enable
// - concurrent region unreadable during erase, write
// - lock set takes data, ignores pointer
// - zero data bits program lock bits
// - eeprom write blocks programming, fuse reads
// - lock read by load within three
// - lock access bits clear themselves
// - pointer selects fuse or lock byte
// - programmed bits read zero
// - load addresses bytes, store addresses words
// - store ignored outside the boot region
// - lock bits never unprogrammed here
`timescale 1ns/10ps
module fspu_top #(
  parameter int PW        = 32,   // words per page
  parameter int RWW_PAGES = 96    // pages below this form the concurrent region
) (
  input  wire logic                              core_clk,     // cpu clock
  input  wire logic                              rst_n,        // async reset
  input  wire logic [fspu_pkg::ADDR_W-1:0]       paddr,        // apb address
  input  wire logic                              psel,         // apb select
  input  wire logic                              penable,      // apb enable
  input  wire logic                              pwrite,       // apb direction
  input  wire logic [31:0]                       pwdata,       // apb write data
  output logic      [31:0]                       prdata,       // apb read data
  output logic                                   pready,       // apb ready
  output logic                                   pslverr,      // apb error
  input  wire logic                              execInBoot,   // cpu runs boot code
  input  wire logic                              eepromWriteActive, // eeprom busy
  input  wire logic [7:0]                        fuseLow,      // fuse low byte
  input  wire logic [7:0]                        fuseHigh,     // fuse high byte
  input  wire logic [7:0]                        fuseExt,      // extended fuse byte
  input  wire logic [5:0]                        lockBitsNv,   // stored lock bits
  output logic      [fspu_pkg::Z_W-2:0]          flashRdAddr,  // word read address
  input  wire logic [15:0]                       flashRdWord,  // word read data
  output logic                                   flashOpStart, // operation start
  output fspu_pkg::fspu_op_t                     flashOpKind,  // operation kind
  output logic      [fspu_pkg::Z_W-2-$clog2(PW):0] flashPage,  // latched page
  output logic      [5:0]                        flashLockData, // lock program data
  input  wire logic                              flashDone,    // operation finished
  input  wire logic [$clog2(PW)-1:0]             bufRdIdx,     // buffer read slot
  output logic      [15:0]                       bufRdData,    // buffer read word
  output logic                                   cpuStall,     // halt cpu fetch
  output logic                                   concurrentReadBlock, // region busy
  output logic                                   spmIrq        // completion request
);
  import fspu_pkg::*;
  localparam int IW  = $clog2(PW);
  localparam int PGW = Z_W - 1 - IW;
  if (PW < 2 || PW > 128 || RWW_PAGES < 1 || RWW_PAGES > 2 ** PGW)
    $error("fspu_top: page parameters out of range");

  typedef struct packed {
    fspu_state_t       st;
    logic [5:0]        cmd;
    logic              ie;
    logic              busyConc;
    logic [Z_W-1:0]    zptr;
    logic [WORD_W-1:0] data;
    fspu_op_t          kind;
    logic [PGW-1:0]    page;
    logic              tgtConc;
    logic [5:0]        lockData;
    logic              opStart;
    logic [7:0]        result;
    logic [31:0]       rdata;
    logic              slvErr;
  } fspu_top_st_t;
  fspu_top_st_t s;
  fspu_top_st_t next_s;

  function automatic logic inConc(input logic [PGW-1:0] pg);
    inConc = 32'(pg) < RWW_PAGES;
  endfunction : inConc

  logic           setup;
  logic           wrAcc;
  logic           ctrlWr;
  logic           insnWr;
  logic           spmHit;
  logic           lpmReq;
  logic           lpmFuse;
  logic           arm;
  logic           cancel;
  logic           spmOk;
  logic           lpmOk;
  logic           expire;
  logic           bufWr;
  logic           bufClr;
  logic [PGW-1:0] zPage;
  logic [5:0]     dataLow;

  fspu_buf_if #(.PW(PW)) bufBus ();

  fspu_window winU (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .arm      (arm),
    .cancel   (cancel),
    .spmOk    (spmOk),
    .lpmOk    (lpmOk),
    .expire   (expire)
  );

  fspu_page_buf #(.PW(PW)) bufU (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (bufBus.store)
  );

  // ==========================================================
  // request decode
  assign setup   = psel && !penable;
  assign wrAcc   = psel && penable && pwrite;
  assign insnWr  = wrAcc && paddr == OFF_INSN;
  assign zPage   = s.zptr[Z_W-1 -: PGW];
  assign dataLow = s.data[5:0];
  assign ctrlWr  = wrAcc && paddr == OFF_CTRL && s.st != ST_BUSY && !eepromWriteActive;
  // store honoured only from boot code
  assign spmHit  = insnWr && pwdata[INSN_SPM] && s.st == ST_ARMED && spmOk
                   && execInBoot && !eepromWriteActive;
  assign lpmReq  = insnWr && pwdata[INSN_LPM];
  // lock access load inside its window
  assign lpmFuse = lpmReq && s.st == ST_ARMED && lpmOk && s.cmd == CMD_LOCK
                   && !eepromWriteActive;

  // ==========================================================
  // sequencer
  always_comb
  begin
    next_s         = s;
    next_s.opStart = 1'b0;
    bufWr          = 1'b0;
    bufClr         = 1'b0;
    arm            = 1'b0;
    cancel         = 1'b0;
    // read data prepared in the setup phase so it is a flop at access
    if (setup)
    begin
      next_s.slvErr = 1'b0;
      next_s.rdata  = '0;
      unique case (paddr)
        OFF_CTRL:   next_s.rdata = 32'({s.ie, s.busyConc, s.cmd});
        OFF_ZPTR:   next_s.rdata = 32'(s.zptr);
        OFF_DATA:   next_s.rdata = 32'(s.data);
        OFF_INSN:   next_s.rdata = '0;
        OFF_RESULT: next_s.rdata = 32'(s.result);
        OFF_STATUS: next_s.rdata = 32'({s.tgtConc, s.st == ST_BUSY, s.page});
        default:    next_s.slvErr = 1'b1;
      endcase
    end
    if (ctrlWr)
    begin
      next_s.cmd = {1'b0, pwdata[4:0]};
      next_s.ie  = pwdata[BIT_IE];
      arm        = pwdata[BIT_EN];
      next_s.st  = pwdata[BIT_EN] ? ST_ARMED : ST_IDLE;
    end
    if (wrAcc && paddr == OFF_ZPTR)
      next_s.zptr = pwdata[Z_W-1:0];
    if (wrAcc && paddr == OFF_DATA)
      next_s.data = pwdata[WORD_W-1:0];
    if (spmHit)
    begin
      cancel     = 1'b1;
      next_s.st  = ST_IDLE;
      next_s.cmd = '0;
      unique case (s.cmd)
        CMD_ERASE, CMD_WRITE:
        begin
          next_s.st      = ST_BUSY;
          next_s.cmd     = s.cmd;
          next_s.opStart = 1'b1;
          next_s.kind    = (s.cmd == CMD_ERASE) ? OP_ERASE : OP_WRITE;
          // page index latched, word bits dropped
          next_s.page    = zPage;
          next_s.tgtConc = inConc(zPage);
          next_s.busyConc = 1'b1;
        end
        CMD_LOCK:
        begin
          next_s.st       = ST_BUSY;
          next_s.cmd      = s.cmd;
          next_s.opStart  = 1'b1;
          next_s.kind     = OP_LOCK;
          next_s.tgtConc  = 1'b0;
          next_s.lockData = dataLow;
        end
        // word slot from the word field
        CMD_LOAD: bufWr = 1'b1;
        CMD_REEN:
        begin
          bufClr          = 1'b1;
          next_s.busyConc = 1'b0;
        end
        default: next_s.cmd = '0;
      endcase
    end
    if (lpmFuse)
    begin
      // lock access clears after the read
      cancel     = 1'b1;
      next_s.st  = ST_IDLE;
      next_s.cmd = '0;
      // bytes passed as stored, programmed reads zero
      unique case (s.zptr)
        Z_FUSE_LO:  next_s.result = fuseLow;
        Z_LOCK:     next_s.result = {LOCK_RD_PAD, lockBitsNv};
        Z_FUSE_EXT: next_s.result = fuseExt;
        Z_FUSE_HI:  next_s.result = fuseHigh;
        default:    next_s.result = ERASED_BYTE;
      endcase
    end
    else if (lpmReq)
    begin
      // byte select from pointer bit zero
      next_s.result = s.zptr[0] ? flashRdWord[15:8] : flashRdWord[7:0];
    end
    if (expire)
    begin
      next_s.st  = ST_IDLE;
      next_s.cmd = '0;
    end
    // enable falls when the operation ends
    if (s.st == ST_BUSY && flashDone)
    begin
      next_s.st  = ST_IDLE;
      next_s.cmd = '0;
      if (s.kind == OP_WRITE)
        bufClr = 1'b1;
    end
    // eeprom write loses the loaded words
    if (eepromWriteActive && bufBus.loaded)
      bufClr = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // ==========================================================
  // outputs
  assign bufBus.wr     = bufWr;
  assign bufBus.wrIdx  = s.zptr[IW:1];
  assign bufBus.wrData = s.data;
  assign bufBus.clr    = bufClr;
  assign bufBus.rdIdx  = bufRdIdx;
  assign bufRdData     = bufBus.rdData;

  assign prdata        = s.rdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && s.slvErr;
  assign flashRdAddr   = s.zptr[Z_W-1:1];
  assign flashOpStart  = s.opStart;
  assign flashOpKind   = s.kind;
  assign flashPage     = s.page;
  // only zeros program; nothing here raises a lock bit
  assign flashLockData = s.lockData;
  // halting region target stalls fetch, lock set never does
  assign cpuStall      = s.st == ST_BUSY && !s.tgtConc && s.kind != OP_LOCK;
  assign concurrentReadBlock = s.busyConc;
  assign spmIrq        = s.ie && !s.cmd[BIT_EN];

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_erase_start: assert property (
    spmHit && s.cmd == CMD_ERASE |=> flashOpStart && flashOpKind == OP_ERASE)
    else $error("erase did not start");
  a_erase_page: assert property (
    spmHit && s.cmd == CMD_ERASE |=> flashPage == $past(zPage))
    else $error("erase page not latched");
  a_page_latch: assert property (
    s.st == ST_BUSY && $past(s.st) == ST_BUSY |-> $stable(flashPage))
    else $error("page changed during operation");
  a_halt_stall: assert property (
    spmHit && (s.cmd == CMD_ERASE || s.cmd == CMD_WRITE) && !inConc(zPage) |=> cpuStall)
    else $error("no stall for halting region");
  a_irq_level: assert property (
    s.st == ST_BUSY && flashDone && s.ie |=> spmIrq)
    else $error("no request after completion");
  a_busy_hold: assert property (
    s.busyConc && !(spmHit && s.cmd == CMD_REEN) |=> concurrentReadBlock)
    else $error("busy flag fell early");
  a_eeprom_block: assert property (
    eepromWriteActive |=> !flashOpStart)
    else $error("programming during eeprom write");
  a_boot_only: assert property (
    !execInBoot |=> !flashOpStart)
    else $error("store honoured outside boot");
  a_lock_mask: assert property (
    spmHit && s.cmd == CMD_LOCK |=> flashLockData == $past(dataLow))
    else $error("lock data not taken");
  a_window_lapse: assert property (
    expire |=> !s.cmd[BIT_EN] && !flashOpStart)
    else $error("enable kept after window");
  a_fuse_high: assert property (
    lpmFuse && s.zptr == Z_FUSE_HI |=> s.result == $past(fuseHigh))
    else $error("wrong fuse byte");
endmodule : fspu_top

// [sim/fspu_flash_model.sv]
// flash array model: word reads and operation timing
`timescale 1ns/10ps
module fspu_flash_model #(
  parameter int DLY = 20                 // cycles one operation takes
) (
  input  wire logic        core_clk,     // cpu clock
  input  wire logic        rst_n,        // async reset, active low
  input  wire logic [14:0] flashRdAddr,  // word read address
  input  wire logic        flashOpStart, // operation start
  output logic      [15:0] flashRdWord,  // word read data
  output logic             flashDone     // operation finished
);
  int cnt;
  // ==========================================================
  // array contents, high byte differs from low so byte select shows
  assign flashRdWord = {~flashRdAddr[7:0], flashRdAddr[7:0]};
  // ==========================================================
  // operation timing
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt       <= 0;
      flashDone <= 1'b0;
    end
    else
    begin
      flashDone <= (cnt == 1);
      if (flashOpStart)
        cnt <= DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule : fspu_flash_model

// [sim/fspu_top_tb.sv]
// self-checking bench of the flash self-programming unit
`timescale 1ns/10ps
module fspu_top_tb;
  import fspu_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, flashOpStart, flashDone, cpuStall, concurrentReadBlock, spmIrq;
  logic execInBoot = 1'b1, eepromWriteActive = 1'b0;
  logic [7:0] fuseLow = 8'he2, fuseHigh = 8'hdf, fuseExt = 8'hf9;
  logic [5:0] lockBitsNv = 6'h2c, flashLockData, lastLock;
  logic [14:0] flashRdAddr;
  logic [15:0] flashRdWord, bufRdData;
  logic [9:0] flashPage, lastPage;
  logic [4:0] bufRdIdx = 5'h00;
  fspu_op_t flashOpKind, lastKind;
  int errTotal = 0, nChecks = 0, nStart = 0;
  logic [31:0] r;
  logic rErr;

  always #12.5 core_clk = ~core_clk;

  fspu_top fspu_top_i (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .execInBoot(execInBoot), .eepromWriteActive(eepromWriteActive),
    .fuseLow(fuseLow), .fuseHigh(fuseHigh), .fuseExt(fuseExt), .lockBitsNv(lockBitsNv),
    .flashRdAddr(flashRdAddr), .flashRdWord(flashRdWord), .flashOpStart(flashOpStart),
    .flashOpKind(flashOpKind), .flashPage(flashPage), .flashLockData(flashLockData),
    .flashDone(flashDone), .bufRdIdx(bufRdIdx), .bufRdData(bufRdData), .cpuStall(cpuStall),
    .concurrentReadBlock(concurrentReadBlock), .spmIrq(spmIrq));
  fspu_flash_model fspu_flash_model_i (.core_clk(core_clk), .rst_n(rst_n),
    .flashRdAddr(flashRdAddr), .flashOpStart(flashOpStart), .flashRdWord(flashRdWord),
    .flashDone(flashDone));

  // ==========================================================
  // start pulse monitor
  always @(posedge core_clk)
    if (flashOpStart === 1'b1)
    begin
      nStart++;
      lastPage = flashPage;
      lastKind = flashOpKind;
      lastLock = flashLockData;
    end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    r    = prdata;
    rErr = pslverr;
  endtask : xfer

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // command and store back to back, well inside the window
  task automatic spm(input logic [7:0] c);
    wr(OFF_CTRL, {24'h0, c});
    wr(OFF_INSN, 32'h1);
    idle();
  endtask : spm

  task automatic waitIdle();
    do
      rd(OFF_CTRL);
    while (r[BIT_EN] !== 1'b0);
    idle();
  endtask : waitIdle

  task automatic slot(input logic [4:0] i, input logic [15:0] e, input string what);
    bufRdIdx <= i;
    @(posedge core_clk);
    chk({16'h0, bufRdData}, {16'h0, e}, what);
  endtask : slot

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(OFF_CTRL);
    chk(r, 32'h0, "ctrl reset");
    rd(OFF_STATUS);
    idle();
    chk(r, 32'h0, "status reset");
    chk({31'h0, rErr}, 32'h0, "mapped no error");
    rd(8'h18);
    idle();
    chk({31'h0, rErr}, 32'h1, "unmapped error");
    chk({cpuStall, concurrentReadBlock, spmIrq}, 32'h0, "outputs reset");
    slot(5'h00, ERASED_WORD, "buffer reset");
    $display("done reset");
  endtask : t_reset

  task automatic t_load();
    wr(OFF_ZPTR, 32'h0006);
    wr(OFF_DATA, 32'h1234);
    spm({2'b00, CMD_LOAD});
    wr(OFF_ZPTR, 32'h003e);
    wr(OFF_DATA, 32'habcd);
    spm({2'b00, CMD_LOAD});
    slot(5'h03, 16'h1234, "slot 3");
    slot(5'h1f, 16'habcd, "slot 31");
    eepromWriteActive <= 1'b1;
    @(posedge core_clk);
    eepromWriteActive <= 1'b0;
    @(posedge core_clk);
    slot(5'h1f, ERASED_WORD, "eeprom discard");
    $display("done load");
  endtask : t_load

  task automatic t_erase();
    int s;
    s = nStart;
    wr(OFF_ZPTR, 32'h192a);
    spm({2'b10, CMD_ERASE});
    repeat (2) @(posedge core_clk);
    chk(nStart, s + 1, "erase start");
    chk(lastPage, 10'd100, "erase page");
    chk(lastKind, OP_ERASE, "erase kind");
    chk({cpuStall, concurrentReadBlock}, 2'b11, "halting stall");
    wr(OFF_ZPTR, 32'h0);
    idle();
    chk(flashPage, 10'd100, "page latched");
    waitIdle();
    repeat (3) @(posedge core_clk);
    chk({spmIrq, concurrentReadBlock, cpuStall}, 3'b110, "irq level busy held");
    spm({2'b00, CMD_REEN});
    repeat (2) @(posedge core_clk);
    chk({spmIrq, concurrentReadBlock}, 2'b00, "reenable clears");
    $display("done erase");
  endtask : t_erase

  task automatic t_write();
    wr(OFF_ZPTR, 32'h0);
    wr(OFF_DATA, 32'h5555);
    spm({2'b00, CMD_LOAD});
    wr(OFF_ZPTR, 32'h0280);
    spm({2'b00, CMD_WRITE});
    repeat (2) @(posedge core_clk);
    chk({lastKind, lastPage}, {OP_WRITE, 10'd10}, "write kind page");
    chk({cpuStall, concurrentReadBlock}, 2'b01, "concurrent no stall");
    waitIdle();
    slot(5'h00, ERASED_WORD, "clear after write");
    spm({2'b00, CMD_REEN});
    $display("done write");
  endtask : t_write

  task automatic t_lock();
    wr(OFF_ZPTR, {16'h0, Z_LOCK});
    wr(OFF_DATA, 32'h00c5);
    spm({2'b00, CMD_LOCK});
    repeat (2) @(posedge core_clk);
    chk({lastKind, lastLock}, {OP_LOCK, 6'h05}, "lock data");
    chk({cpuStall, concurrentReadBlock}, 2'b00, "lock readable");
    waitIdle();
    $display("done lock");
  endtask : t_lock

  task automatic t_fuse();
    logic [7:0] e[4];
    e = '{fuseLow, {LOCK_RD_PAD, lockBitsNv}, fuseExt, fuseHigh};
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_ZPTR, 32'(i));
      wr(OFF_CTRL, {26'h0, CMD_LOCK});
      wr(OFF_INSN, 32'h2);
      rd(OFF_RESULT);
      chk(r[7:0], e[i], "fuse lock byte");
      rd(OFF_CTRL);
      idle();
      chk(r[7:0], 8'h00, "access bits clear");
    end
    $display("done fuse");
  endtask : t_fuse

  task automatic t_lapse();
    int s;
    s = nStart;
    wr(OFF_CTRL, {24'h0, 2'b10, CMD_ERASE});
    idle();
    repeat (6) @(posedge core_clk);
    wr(OFF_INSN, 32'h1);
    rd(OFF_CTRL);
    idle();
    chk(r[7:0], 8'h80, "lapsed enable");
    chk({nStart == s, spmIrq}, 2'b11, "no op irq");
    wr(OFF_CTRL, 32'h0);
    idle();
    $display("done lapse");
  endtask : t_lapse

  task automatic t_block();
    int s;
    s = nStart;
    execInBoot <= 1'b0;
    wr(OFF_ZPTR, 32'h0280);
    spm({2'b00, CMD_ERASE});
    execInBoot <= 1'b1;
    repeat (6) @(posedge core_clk);
    eepromWriteActive <= 1'b1;
    spm({2'b00, CMD_ERASE});
    chk(nStart, s, "store refused");
    wr(OFF_ZPTR, 32'h0);
    wr(OFF_CTRL, {26'h0, CMD_LOCK});
    wr(OFF_INSN, 32'h2);
    rd(OFF_RESULT);
    chk(r[7:0], 8'h00, "fuse read blocked");
    eepromWriteActive <= 1'b0;
    wr(OFF_ZPTR, 32'h0005);
    wr(OFF_INSN, 32'h2);
    rd(OFF_RESULT);
    idle();
    chk(r[7:0], 8'hfd, "byte select");
    $display("done block");
  endtask : t_block

  task automatic test_done();
    $display("checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_load();
    t_erase();
    t_write();
    t_lock();
    t_fuse();
    t_lapse();
    t_block();
    test_done();
  end

  initial
  begin
    #(20000 * 25);
    errTotal++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule : fspu_top_tb
